// file: core/mcfs_sequencer.v
// call origination, answering and fax data sequencing with an apb register file
// assumes line-side events (ring, carrier, dial done) arrive synchronous to pclk
`timescale 1ns/10ps
`default_nettype none
`include "mcfs_defines.vh"
module mcfs_sequencer #(
  parameter MS_CYC       = `MCFS_MS_CYC,
  parameter ANS_TONE_MS  = `MCFS_ANS_TONE_MS,
  parameter CALL_ON_MS   = `MCFS_CALL_ON_MS,
  parameter CALL_OFF_MS  = `MCFS_CALL_OFF_MS,
  parameter NULL_TO_MS   = `MCFS_NULL_TO_MS,
  parameter TRAIN_MS     = `MCFS_TRAIN_MS
) (
  input  wire        pclk,            // apb clock
  input  wire        presetn,         // async reset, low
  input  wire        clk_en,          // freezes state when low
  input  wire        psel,            // apb select
  input  wire        penable,         // apb enable
  input  wire        pwrite,          // apb direction
  input  wire [11:0] paddr,           // apb address
  input  wire [31:0] pwdata,          // apb write data
  output reg  [31:0] prdata,          // apb read data
  output wire        pready,          // apb ready
  output wire        pslverr,         // apb error
  input  wire        ring_det,        // one-cycle ring pulse
  input  wire        dial_done,       // dialer finished pulse
  input  wire        carrier_ok,      // selected carrier present
  input  wire        other_signal,    // non-selected signal seen
  input  wire        remote_2400,     // remote offers 2400
  input  wire        remote_300,      // remote originator offers 300
  input  wire        rx_valid,        // demodulated byte valid
  input  wire [7:0]  rx_byte,         // demodulated byte
  input  wire        tx_take,         // modulator takes a byte
  input  wire        parallel_mode,   // host interface parallel
  output reg         off_hook,        // line relay
  output reg         tone_on,         // tone generator on
  output reg         tone_2225,       // alternate answer tone, never asserted
  output reg         tone_1100,       // fax calling tone
  output reg         carrier_tx,      // modulator carrier on
  output reg         train_tx,        // training sequence active
  output reg  [7:0]  tx_byte,         // byte to modulator
  output reg         demod_on,        // demodulator active
  output reg         dial_start,      // dialer start pulse
  output reg         dial_pulse,      // pulse dial method
  output reg         pps_20,          // 20 pps pulse rate
  output reg  [3:0]  line_att_db2,    // line attenuation in 2 dB units
  output reg  [3:0]  tone_att_db2,    // tone attenuation in 2 dB units
  output reg         use_second_def,  // secondary default set
  output reg  [1:0]  line_rate,       // connection rate code
  output reg         async_10bit,     // async 10-bit characters
  output wire        cts,             // clear to send
  output wire        dsr              // data set ready
);
  // ==========================================================
  // states
  localparam ST_IDLE  = 4'h0;
  localparam ST_DIAL  = 4'h1;
  localparam ST_CALL  = 4'h2;
  localparam ST_ANST  = 4'h3;
  localparam ST_DHS   = 4'h4;
  localparam ST_FHS   = 4'h5;
  localparam ST_TRAIN = 4'h6;
  localparam ST_TXD   = 4'h7;
  localparam ST_NULL  = 4'h8;
  localparam ST_RSRCH = 4'h9;
  localparam ST_RXD   = 4'ha;
  function [31:0] ms2cyc;
    input [31:0] ms;
    ms2cyc = ms * MS_CYC;
  endfunction
  function [1:0] nego_rate;
    input orig_300;
    input both_2400;
    nego_rate = orig_300 ? `MCFS_RATE_300 : (both_2400 ? `MCFS_RATE_2400 : `MCFS_RATE_1200);
  endfunction
  // ==========================================================
  // registers
  reg  [7:0]  opt_reg;
  reg         fax_class_reg;
  reg  [7:0]  ring_count_reg;
  reg         offer_2400_reg;
  reg         offer_300_reg;
  reg  [7:0]  rings_seen_reg;
  reg  [3:0]  state_reg;
  reg  [2:0]  result_reg;
  reg         result_new_reg;
  reg  [31:0] timer_reg;
  reg  [7:0]  tx_hold_reg;
  reg         tx_full_reg;
  reg         last_null_reg;
  reg         tx_paused_reg;
  reg         rx_paused_reg;
  reg  [7:0]  rx_hold_reg;
  reg         rx_full_reg;
  reg         ring_flag_reg;
  reg         originate_reg;
  wire        acc    = psel && penable && clk_en;
  wire        wr     = acc && pwrite;
  wire        rd     = acc && !pwrite;
  wire        hit    = (paddr == `MCFS_OPT_OFF) || (paddr == `MCFS_CMD_OFF) ||
                       (paddr == `MCFS_CTRL_OFF) || (paddr == `MCFS_STAT_OFF) ||
                       (paddr == `MCFS_TXD_OFF) || (paddr == `MCFS_RXD_OFF);
  wire        cmd_wr = wr && (paddr == `MCFS_CMD_OFF);
  wire [3:0]  cmd    = cmd_wr ? pwdata[3:0] : `MCFS_CMD_NONE;
  wire        txd_wr = wr && (paddr == `MCFS_TXD_OFF);
  wire        rxd_rd = rd && (paddr == `MCFS_RXD_OFF);
  wire        is_fc  = (pwdata[7:0] == `MCFS_CHR_PAUSE) || (pwdata[7:0] == `MCFS_CHR_RESUME);
  assign pready  = 1'b1;
  assign pslverr = psel && penable && !hit;
  assign cts     = 1'b1;
  assign dsr     = parallel_mode;
  always @*
  begin
    prdata = 32'h00000000;
    case (paddr)
      `MCFS_OPT_OFF:  prdata = {24'h000000, opt_reg};
      `MCFS_CTRL_OFF: prdata = {14'h0000, offer_300_reg, offer_2400_reg, ring_count_reg, 7'h00, fax_class_reg};
      `MCFS_STAT_OFF: prdata = {18'h00000, rx_full_reg, tx_full_reg, ring_flag_reg, result_new_reg,
                                line_rate, result_reg, off_hook, state_reg};
      `MCFS_RXD_OFF:  prdata = {24'h000000, rx_hold_reg};
      default:        prdata = 32'h00000000;
    endcase
  end

  // decoded option outputs
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      line_att_db2   <= 4'h0;
      tone_att_db2   <= 4'h0;
      pps_20         <= 1'b0;
      use_second_def <= 1'b0;
      dial_pulse     <= 1'b0;
      async_10bit    <= 1'b1;
    end
    else if (clk_en)
    begin
      line_att_db2   <= {1'b0, opt_reg[`MCFS_OPT_LATT_LSB +: 3]};
      tone_att_db2   <= {1'b0, opt_reg[`MCFS_OPT_TATT_LSB +: 3]};
      pps_20         <= opt_reg[`MCFS_OPT_PPS_BIT];
      use_second_def <= opt_reg[`MCFS_OPT_DEF_BIT];
      dial_pulse     <= opt_reg[`MCFS_OPT_DIAL_BIT];
      async_10bit    <= (line_rate != `MCFS_RATE_2400);
    end
  end

  // ==========================================================
  // sequencer
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      opt_reg        <= `MCFS_OPT_RST;
      fax_class_reg  <= 1'b0;
      ring_count_reg <= 8'h00;
      offer_2400_reg <= 1'b1;
      offer_300_reg  <= 1'b0;
      rings_seen_reg <= 8'h00;
      state_reg      <= ST_IDLE;
      result_reg     <= `MCFS_RES_NONE;
      result_new_reg <= 1'b0;
      timer_reg      <= 32'h00000000;
      tx_hold_reg    <= 8'h00;
      tx_full_reg    <= 1'b0;
      last_null_reg  <= 1'b0;
      tx_paused_reg  <= 1'b0;
      rx_paused_reg  <= 1'b0;
      rx_hold_reg    <= 8'h00;
      rx_full_reg    <= 1'b0;
      ring_flag_reg  <= 1'b0;
      originate_reg  <= 1'b0;
      off_hook       <= 1'b0;
      tone_on        <= 1'b0;
      tone_2225      <= 1'b0;
      tone_1100      <= 1'b0;
      carrier_tx     <= 1'b0;
      train_tx       <= 1'b0;
      tx_byte        <= 8'h00;
      demod_on       <= 1'b0;
      dial_start     <= 1'b0;
      line_rate      <= `MCFS_RATE_1200;
    end
    else if (clk_en)
    begin
      dial_start <= 1'b0;
      if (wr && paddr == `MCFS_OPT_OFF)
        opt_reg <= pwdata[7:0];
      if (wr && paddr == `MCFS_CTRL_OFF)
      begin
        fax_class_reg  <= pwdata[0];
        ring_count_reg <= pwdata[15:8];
        offer_2400_reg <= pwdata[16];
        offer_300_reg  <= pwdata[17];
      end
      // status read clears result and ring flags; a new event wins
      if (rd && paddr == `MCFS_STAT_OFF)
      begin
        result_new_reg <= 1'b0;
        ring_flag_reg  <= 1'b0;
      end
      if (rxd_rd)
        rx_full_reg <= 1'b0;
      if (timer_reg != 32'h00000000)
        timer_reg <= timer_reg - 32'h00000001;

      case (state_reg)
        ST_IDLE:
        begin
          if (ring_det)
          begin
            ring_flag_reg  <= 1'b1;
            result_reg     <= `MCFS_RES_RING;
            result_new_reg <= 1'b1;
            rings_seen_reg <= rings_seen_reg + 8'h01;
          end
          if (cmd == `MCFS_CMD_DIAL)
          begin
            dial_start    <= 1'b1;
            originate_reg <= 1'b1;
            off_hook      <= 1'b1;
            state_reg     <= ST_DIAL;
            if (pwdata[8])
              opt_reg[`MCFS_OPT_DIAL_BIT] <= pwdata[9];
          end
          else if (cmd == `MCFS_CMD_ANSWER ||
                   (ring_det && ring_count_reg != 8'h00 && rings_seen_reg + 8'h01 >= ring_count_reg))
          begin
            off_hook       <= 1'b1;
            originate_reg  <= 1'b0;
            rings_seen_reg <= 8'h00;
            tone_on        <= 1'b1;
            tone_2225      <= opt_reg[`MCFS_OPT_DEF_BIT] ? 1'b0 : 1'b0;
            timer_reg      <= ms2cyc(ANS_TONE_MS);
            state_reg      <= ST_ANST;
          end
          else if (cmd == `MCFS_CMD_FTX)
          begin
            carrier_tx     <= 1'b1;
            train_tx       <= 1'b1;
            result_reg     <= `MCFS_RES_CONNECT;
            result_new_reg <= 1'b1;
            tx_byte        <= 8'hff;
            last_null_reg  <= 1'b0;
            timer_reg      <= ms2cyc(TRAIN_MS);
            state_reg      <= ST_TRAIN;
          end
          else if (cmd == `MCFS_CMD_FRX)
          begin
            demod_on  <= 1'b1;
            state_reg <= ST_RSRCH;
          end
        end
        ST_DIAL:
          if (dial_done)
          begin
            if (fax_class_reg)
            begin
              tone_on   <= 1'b1;
              tone_1100 <= 1'b1;
              timer_reg <= ms2cyc(CALL_ON_MS);
              state_reg <= ST_CALL;
            end
            else
            begin
              line_rate <= nego_rate(offer_300_reg, offer_2400_reg && remote_2400);
              state_reg <= ST_DHS;
            end
          end
        ST_CALL:
          if (carrier_ok)
          begin
            tone_on   <= 1'b0;
            tone_1100 <= 1'b0;
            state_reg <= ST_FHS;
          end
          else if (timer_reg == 32'h00000000)
          begin
            tone_on   <= !tone_on;
            timer_reg <= tone_on ? ms2cyc(CALL_OFF_MS) : ms2cyc(CALL_ON_MS);
          end
        ST_ANST:
          if (timer_reg == 32'h00000000)
          begin
            tone_on   <= 1'b0;
            tone_2225 <= 1'b0;
            if (fax_class_reg)
              state_reg <= ST_FHS;
            else
            begin
              line_rate <= nego_rate(remote_300, offer_2400_reg && remote_2400);
              state_reg <= ST_DHS;
            end
          end
        ST_TRAIN:
          if (timer_reg == 32'h00000000)
          begin
            train_tx  <= 1'b0;
            state_reg <= ST_TXD;
          end
        ST_TXD, ST_NULL:
        begin
          if (tx_take && tx_full_reg && !tx_paused_reg)
          begin
            tx_byte       <= tx_hold_reg;
            tx_full_reg   <= 1'b0;
            last_null_reg <= (tx_hold_reg == `MCFS_CHR_NUL);
            state_reg     <= ST_TXD;
          end
          else if (tx_take && !tx_full_reg && state_reg == ST_TXD)
          begin
            if (last_null_reg)
            begin
              tx_byte   <= `MCFS_CHR_NUL;
              timer_reg <= ms2cyc(NULL_TO_MS);
              state_reg <= ST_NULL;
            end
            else if (tx_byte != 8'hff || train_tx)
            begin
              carrier_tx     <= 1'b0;
              result_reg     <= `MCFS_RES_OK;
              result_new_reg <= 1'b1;
              state_reg      <= ST_IDLE;
            end
          end
          else if (state_reg == ST_NULL && timer_reg == 32'h00000000)
          begin
            carrier_tx     <= 1'b0;
            result_reg     <= `MCFS_RES_ERROR;
            result_new_reg <= 1'b1;
            state_reg      <= ST_IDLE;
          end
          if (txd_wr && state_reg == ST_NULL)
            timer_reg <= ms2cyc(NULL_TO_MS);
        end
        ST_RSRCH:
          if (carrier_ok)
          begin
            result_reg     <= `MCFS_RES_CONNECT;
            result_new_reg <= 1'b1;
            state_reg      <= ST_RXD;
          end
          else if (other_signal)
          begin
            demod_on       <= 1'b0;
            result_reg     <= `MCFS_RES_MISMATCH;
            result_new_reg <= 1'b1;
            state_reg      <= ST_IDLE;
          end
        ST_RXD:
          if (!carrier_ok)
          begin
            demod_on       <= 1'b0;
            result_reg     <= `MCFS_RES_NOCARRIER;
            result_new_reg <= 1'b1;
            state_reg      <= ST_IDLE;
          end
          else if (txd_wr && !is_fc)
          begin
            demod_on  <= 1'b0;
            state_reg <= ST_IDLE;
          end
          else if (rx_valid && !rx_full_reg && !rx_paused_reg)
          begin
            rx_hold_reg <= rx_byte;
            rx_full_reg <= 1'b1;
          end
        default:
          state_reg <= ST_IDLE;
      endcase

      // host characters: flow control codes steer both directions
      if (txd_wr && is_fc)
      begin
        tx_paused_reg <= (pwdata[7:0] == `MCFS_CHR_PAUSE);
        rx_paused_reg <= (pwdata[7:0] == `MCFS_CHR_PAUSE);
      end
      else if (txd_wr && !tx_full_reg && (state_reg == ST_TRAIN || state_reg == ST_TXD || state_reg == ST_NULL))
      begin
        tx_hold_reg <= pwdata[7:0];
        tx_full_reg <= 1'b1;
      end

      if (cmd == `MCFS_CMD_HANGUP)
      begin
        off_hook   <= 1'b0;
        tone_on    <= 1'b0;
        tone_1100  <= 1'b0;
        carrier_tx <= 1'b0;
        train_tx   <= 1'b0;
        demod_on   <= 1'b0;
        tx_full_reg <= 1'b0;
        state_reg  <= ST_IDLE;
      end
    end
  end
endmodule
`default_nettype wire

// file: shared/mcfs_defines.vh
// constants for the modem call/fax sequencer: register offsets, fields, codes, timing
// assumes a 40 MHz pclk and an apb register bus with 32-bit data
`ifndef MCFS_DEFINES_VH
`define MCFS_DEFINES_VH
// register byte offsets
`define MCFS_OPT_OFF        12'h000
`define MCFS_CMD_OFF        12'h004
`define MCFS_CTRL_OFF       12'h008
`define MCFS_STAT_OFF       12'h00c
`define MCFS_TXD_OFF        12'h010
`define MCFS_RXD_OFF        12'h014
`define MCFS_OPT_RST        8'h00
// option fields
`define MCFS_OPT_LATT_LSB   0
`define MCFS_OPT_TATT_LSB   3
`define MCFS_OPT_PPS_BIT    6
`define MCFS_OPT_DEF_BIT    7
`define MCFS_OPT_DIAL_BIT   5
// commands, written to the command register
`define MCFS_CMD_NONE       4'h0
`define MCFS_CMD_DIAL       4'h1
`define MCFS_CMD_ANSWER     4'h2
`define MCFS_CMD_FTX        4'h3
`define MCFS_CMD_FRX        4'h4
`define MCFS_CMD_HANGUP     4'h5
// result codes
`define MCFS_RES_NONE       3'h0
`define MCFS_RES_OK         3'h1
`define MCFS_RES_CONNECT    3'h2
`define MCFS_RES_RING       3'h3
`define MCFS_RES_NOCARRIER  3'h4
`define MCFS_RES_ERROR      3'h5
`define MCFS_RES_MISMATCH   3'h6
// rate codes
`define MCFS_RATE_300       2'h0
`define MCFS_RATE_1200      2'h1
`define MCFS_RATE_2400      2'h2
// characters
`define MCFS_CHR_NUL        8'h00
`define MCFS_CHR_RESUME     8'h11
`define MCFS_CHR_PAUSE      8'h13
// timing
`define MCFS_CLK_HZ         40000000
`define MCFS_ANS_TONE_MS    3000
`define MCFS_CALL_ON_MS     500
`define MCFS_CALL_OFF_MS    3000
`define MCFS_NULL_TO_MS     5000
`define MCFS_TRAIN_MS       100
`define MCFS_MS_CYC         (`MCFS_CLK_HZ / 1000)
`endif

// file: testbench/mcfs_line_model.sv
// far side model: dialer and modulator byte taker
// assumes pclk domain, dial done six cycles after start
`timescale 1ns/10ps
`default_nettype none
module mcfs_line_model #(
  parameter int GAP = 8
) (
  input  wire logic pclk,       // clock
  input  wire logic presetn,    // reset, low
  input  wire logic dial_start, // dialer start
  input  wire logic carrier_tx, // carrier on
  input  wire logic train_tx,   // training
  output var  logic dial_done,  // dialer finished
  output var  logic tx_take     // byte taken
);
  // ==========================================
  // dialer and modulator pacing
  int dcnt;
  int tcnt;
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      dcnt <= 0;
      tcnt <= 0;
      dial_done <= 1'b0;
      tx_take <= 1'b0;
    end
    else
    begin
      dcnt <= dial_start ? 6 : (dcnt > 0 ? dcnt - 1 : 0);
      dial_done <= (dcnt == 1);
      tcnt <= (tcnt + 1) % GAP;
      tx_take <= carrier_tx && !train_tx && tcnt == 0;
    end
  end
endmodule
`default_nettype wire

// file: testbench/mcfs_seq_properties.sv
// port assertions for the call/fax sequencer
// assumes bind onto mcfs_sequencer, one clock pclk, reset presetn
`timescale 1ns/10ps
`default_nettype none
`include "mcfs_defines.vh"
module mcfs_seq_props (
  input wire logic        pclk,           // clock
  input wire logic        presetn,        // reset, low
  input wire logic        clk_en,         // state enable
  input wire logic        psel,           // apb select
  input wire logic        penable,        // apb enable
  input wire logic        pwrite,         // apb direction
  input wire logic [11:0] paddr,          // apb address
  input wire logic [31:0] pwdata,         // apb write data
  input wire logic        pslverr,        // apb error
  input wire logic        dial_start,     // dialer start
  input wire logic        train_tx,       // training
  input wire logic        carrier_tx,     // carrier on
  input wire logic        tone_on,        // tone on
  input wire logic        tone_2225,      // alternate tone
  input wire logic        off_hook,       // line relay
  input wire logic [3:0]  line_att_db2,   // line attenuation
  input wire logic [3:0]  tone_att_db2,   // tone attenuation
  input wire logic        pps_20,         // pulse rate
  input wire logic        use_second_def, // default set
  input wire logic [1:0]  line_rate,      // rate code
  input wire logic        async_10bit,    // async mode
  input wire logic        cts,            // clear to send
  input wire logic        dsr,            // data set ready
  input wire logic        parallel_mode   // host parallel
);
  // ==========================================
  // properties
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  wire opt_wr = psel && penable && pwrite && clk_en && paddr == `MCFS_OPT_OFF;
  property p_cts; cts; endproperty
  a_cts: assert property (p_cts) else $error("cts dropped");
  property p_dsr; dsr == parallel_mode; endproperty
  a_dsr: assert property (p_dsr) else $error("dsr wrong");
  property p_latt; opt_wr |-> ##2 line_att_db2 == {1'b0, $past(pwdata[2:0], 2)}; endproperty
  a_latt: assert property (p_latt) else $error("line attenuation wrong");
  property p_tatt; opt_wr |-> ##2 tone_att_db2 == {1'b0, $past(pwdata[5:3], 2)}; endproperty
  a_tatt: assert property (p_tatt) else $error("tone attenuation wrong");
  property p_pps; opt_wr |-> ##2 pps_20 == $past(pwdata[6], 2) && use_second_def == $past(pwdata[7], 2); endproperty
  a_pps: assert property (p_pps) else $error("rate or default bit wrong");
  property p_dial; dial_start |=> !dial_start; endproperty
  a_dial: assert property (p_dial) else $error("dial start not a pulse");
  property p_rate; line_rate != 2'h3 && async_10bit == ($past(line_rate) != `MCFS_RATE_2400); endproperty
  a_rate: assert property (p_rate) else $error("rate or char mode wrong");
  property p_tone; tone_on |-> off_hook && !tone_2225; endproperty
  a_tone: assert property (p_tone) else $error("tone while on hook");
  property p_train; train_tx |-> carrier_tx; endproperty
  a_train: assert property (p_train) else $error("training without carrier");
  property p_err; pslverr == (psel && penable && (paddr[1:0] != 2'h0 || paddr > `MCFS_RXD_OFF)); endproperty
  a_err: assert property (p_err) else $error("slave error wrong");
  c_tone: cover property (tone_on);
  c_train: cover property (train_tx);
  c_dial: cover property (dial_start);
  c_err: cover property (pslverr);
endmodule
bind mcfs_sequencer mcfs_seq_props u_props (.*);
`default_nettype wire

// file: testbench/modem_call_fax_sequencer_test.sv
// self-checking bench for the call/fax sequencer
// assumes times shortened by MS_CYC of 4 and the line model
`timescale 1ns/10ps
`default_nettype none
`include "mcfs_defines.vh"
module modem_call_fax_sequencer_test;
  logic        pclk, presetn, clk_en, psel, penable, pwrite, pready, pslverr, e;
  logic        ring_det, dial_done, carrier_ok, other_signal, remote_2400, remote_300;
  logic        rx_valid, tx_take, parallel_mode, off_hook, tone_on, tone_2225, tone_1100;
  logic        carrier_tx, train_tx, demod_on, dial_start, dial_pulse, pps_20;
  logic        use_second_def, async_10bit, cts, dsr;
  logic [7:0]  rx_byte, tx_byte, lf, opt_m;
  logic [3:0]  line_att_db2, tone_att_db2;
  logic [1:0]  line_rate;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, q;
  logic [7:0]  rxq[$];
  logic [11:0] dcmd[3] = '{12'h301, 12'h001, 12'h101};
  int          bad_count, compares, n;
  wire  [5:0]  mon = {tone_1100, dial_start, off_hook, tone_on, carrier_tx, train_tx};
  mcfs_sequencer #(.MS_CYC(4)) dut (.*);
  mcfs_line_model model (.*);
  // ==========================================
  // helpers
  function automatic logic [7:0] lfsr(input logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction
  task chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp)
    begin
      bad_count++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    @(posedge pclk);
    while (pready !== 1'b1 && n < 20)
    begin
      n++;
      @(posedge pclk);
    end
    if (n >= 20) bad_count++;
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task wt(input int b, input logic v, input int lim);
    n = 0;
    while (mon[b] !== v && n < lim)
    begin
      n++;
      @(posedge pclk);
    end
    if (n >= lim) bad_count++;
  endtask
  task stat(input logic [2:0] r);
    apb(0, `MCFS_STAT_OFF, 0);
    chk(q[7:5], r);
  endtask
  task stop_test;
    $display("compares %0d mismatches %0d", compares, bad_count);
    if (bad_count == 0 && compares > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  initial
  begin
    pclk = 1'b0;
    forever #12.5 pclk = ~pclk;
  end
  initial
  begin
    repeat (90000) @(posedge pclk);
    bad_count++;
    $display("watchdog expired");
    stop_test;
  end
  // ==========================================
  // tests
  initial
  begin
    {presetn, clk_en, psel, penable, pwrite, ring_det, carrier_ok, other_signal} = '0;
    {remote_2400, remote_300, rx_valid, parallel_mode, paddr, pwdata, rx_byte} = '0;
    bad_count = 0;
    compares = 0;
    lf = 8'h04;
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    clk_en <= 1'b1;
    parallel_mode <= 1'b1;
    apb(0, `MCFS_OPT_OFF, 0);
    chk(q, 32'h0);
    chk({cts, dsr, async_10bit, line_rate}, 5'h1d);
    repeat (8)
    begin
      lf = lfsr(lf);
      apb(1, `MCFS_OPT_OFF, {24'h0, lf});
      repeat (2) @(posedge pclk);
      chk({pps_20, use_second_def, tone_att_db2, line_att_db2}, {lf[6], lf[7], 1'b0, lf[5:3], 1'b0, lf[2:0]});
    end
    clk_en <= 1'b0;
    apb(1, `MCFS_OPT_OFF, 32'hff);
    clk_en <= 1'b1;
    apb(0, `MCFS_OPT_OFF, 0);
    chk(q, {24'h0, lf});
    apb(0, 12'h020, 0);
    chk(e, 1'b1);
    chk(q, 32'h0);
    $display("options done");
    opt_m = lf;
    apb(1, `MCFS_CTRL_OFF, 32'h0001_0200);
    for (int i = 0; i < 3; i++)
    begin
      if (dcmd[i][8]) opt_m[5] = dcmd[i][9];
      apb(1, `MCFS_CMD_OFF, {20'h0, dcmd[i]});
      wt(4, 1'b1, 50);
      chk(dial_start, 1'b1);
      repeat (10) @(posedge pclk);
      apb(0, `MCFS_OPT_OFF, 0);
      chk({q[5], dial_pulse}, {2{opt_m[5]}});
      apb(1, `MCFS_CMD_OFF, `MCFS_CMD_HANGUP);
    end
    apb(1, `MCFS_CTRL_OFF, 32'h0001_0001);
    apb(1, `MCFS_CMD_OFF, `MCFS_CMD_DIAL);
    wt(2, 1'b1, 100);
    chk(tone_1100, 1'b1);
    wt(2, 1'b0, 3000);
    chk(n >= 1700 && n <= 2300, 1'b1);
    wt(2, 1'b1, 15000);
    chk(n >= 10200 && n <= 13800, 1'b1);
    apb(1, `MCFS_CMD_OFF, `MCFS_CMD_HANGUP);
    $display("dialing done");
    apb(1, `MCFS_CTRL_OFF, 32'h0001_0200);
    remote_300 <= 1'b1;
    carrier_ok <= 1'b1;
    for (int i = 0; i < 2; i++)
    begin
      chk(off_hook, 1'b0);
      ring_det <= 1'b1;
      @(posedge pclk);
      ring_det <= 1'b0;
      stat(`MCFS_RES_RING);
    end
    wt(2, 1'b1, 20);
    wt(2, 1'b0, 17000);
    chk(n >= 10400 && n <= 16000, 1'b1);
    repeat (20) @(posedge pclk);
    apb(0, `MCFS_STAT_OFF, 0);
    chk(q[9:8], `MCFS_RATE_300);
    apb(1, `MCFS_CMD_OFF, `MCFS_CMD_HANGUP);
    {remote_300, carrier_ok} <= 2'b00;
    $display("answer done");
    apb(1, `MCFS_CTRL_OFF, 32'h0001_0001);
    apb(1, `MCFS_CMD_OFF, `MCFS_CMD_FTX);
    stat(`MCFS_RES_CONNECT);
    chk({carrier_tx, train_tx}, 2'b11);
    apb(1, `MCFS_TXD_OFF, `MCFS_CHR_NUL);
    wt(0, 1'b0, 1000);
    repeat (10000) @(posedge pclk);
    apb(1, `MCFS_TXD_OFF, `MCFS_CHR_NUL);
    wt(1, 1'b0, 30000);
    chk(n >= 19900 && n <= 20100, 1'b1);
    stat(`MCFS_RES_ERROR);
    apb(1, `MCFS_CMD_OFF, `MCFS_CMD_FTX);
    wt(0, 1'b0, 1000);
    repeat (2) @(posedge pclk);
    chk(tx_byte, 8'hff);
    apb(1, `MCFS_TXD_OFF, 32'h55);
    wt(1, 1'b0, 2000);
    stat(`MCFS_RES_OK);
    $display("fax transmit done");
    apb(1, `MCFS_CMD_OFF, `MCFS_CMD_FRX);
    @(posedge pclk);
    chk(demod_on, 1'b1);
    other_signal <= 1'b1;
    @(posedge pclk);
    other_signal <= 1'b0;
    stat(`MCFS_RES_MISMATCH);
    chk(demod_on, 1'b0);
    apb(1, `MCFS_CMD_OFF, `MCFS_CMD_FRX);
    carrier_ok <= 1'b1;
    stat(`MCFS_RES_CONNECT);
    lf = lfsr(lf);
    rx_byte <= lf;
    rx_valid <= 1'b1;
    @(posedge pclk);
    rx_valid <= 1'b0;
    rxq.push_back(lf);
    apb(0, `MCFS_RXD_OFF, 0);
    chk(q[7:0], rxq.pop_front());
    apb(1, `MCFS_TXD_OFF, `MCFS_CHR_PAUSE);
    rx_valid <= 1'b1;
    @(posedge pclk);
    rx_valid <= 1'b0;
    apb(0, `MCFS_STAT_OFF, 0);
    chk(q[13], 1'b0);
    apb(1, `MCFS_TXD_OFF, `MCFS_CHR_RESUME);
    chk(demod_on, 1'b1);
    apb(1, `MCFS_TXD_OFF, 32'h41);
    repeat (2) @(posedge pclk);
    chk(demod_on, 1'b0);
    apb(1, `MCFS_CMD_OFF, `MCFS_CMD_FRX);
    repeat (3) @(posedge pclk);
    carrier_ok <= 1'b0;
    repeat (3) @(posedge pclk);
    stat(`MCFS_RES_NOCARRIER);
    $display("fax receive done");
    stop_test;
  end
endmodule
`default_nettype wire
